// file: logic/mss_sequencer.sv
// Speed search sequencer with register port and interrupt
// What this block does
// RULE1 - Command one: estimate, or maximum frequency
// RULE2 - Command two: estimate, or latched reference
// RULE3 - Both commands assigned raises configuration error
// RULE4 - Encoder mode starts at measured frequency
// RULE5 - Sequence holds run and search baseblock long
// RULE6 - Wait search delay before every search
// RULE7 - Current below level completes current search
// RULE8 - Run command searches only for 1/3
// RULE9 - Estimate speed and direction at start
// RULE10 - Current search from loss or maximum
// RULE11 - Selection encodes enable and method bits
// RULE12 - Current level is percent of rated
// RULE13 - Recover voltage over recovery time
// RULE14 - Short loss waits out minimum baseblock
//
// Local design decisions: strobed register access and the address map.
`default_nettype none
`include "mss_defs.svh"
module mss_sequencer
    import mss_pkg::*;
#(
    parameter int CYC_PER_MS = `MSS_CYC_PER_MS
) (
    input  wire logic                clk_i,
    input  wire logic                sys_rst_i,
    input  wire mss_pkg::mss_bus_type bus_i,
    output logic [15:0]              rdata_o,
    input  wire logic [39:0]         term_fn_i,
    input  wire logic                run_i,
    input  wire logic                search_one_i,
    input  wire logic                search_two_i,
    input  wire logic                power_loss_i,
    input  wire logic                encoder_mode_i,
    input  wire mss_pkg::mss_freq_type freq_i,
    input  wire logic [7:0]          current_pct_i,
    output logic                     block_o,
    output logic                     searching_o,
    output logic [15:0]              start_freq_o,
    output logic                     start_dir_o,
    output logic                     start_valid_o,
    output logic                     curdet_o,
    output logic                     ramp_o,
    output logic                     vrec_o,
    output logic                     cfg_err_o,
    output logic                     irq_o
);
    import mss_pkg::*;
    typedef enum logic [2:0] {
        ST_IDLE, ST_BLOCK, ST_WAIT, ST_SEARCH, ST_RECOVER, ST_RUN
    } mss_state_type;
    mss_state_type state_r, state_nxt;
    logic [1:0]  sel_r, sel_nxt;
    logic [15:0] wait_r, wait_nxt, bb_r, bb_nxt, vrec_r, vrec_nxt;
    logic [7:0]  lvl_r, lvl_nxt;
    logic [2:0]  ist_r, ist_nxt, imask_r, imask_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [15:0] freq_r, freq_nxt;
    logic        dir_r, dir_nxt, valid_r, valid_nxt;
    logic        run_q_r, ext_q_r, loss_q_r, from_loss_r, from_loss_nxt;
    logic        use_cur_r, use_cur_nxt;
    logic        has_one, has_two, conflict;
    logic        tim_start, tim_done;
    logic [15:0] tim_ms;
    logic [2:0]  ev;
    logic        ext_req, run_rise, ext_rise, loss_fall, trig;
    logic [15:0] lvl_thr;
    mss_cfg_check u_cfg (
        .term_fn_i  (term_fn_i),
        .has_one_o  (has_one),
        .has_two_o  (has_two),
        .conflict_o (conflict)
    );
    mss_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tim (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (tim_start),
        .ms_i      (tim_ms),
        .done_o    (tim_done)
    );
    // Commands only count on assigned terminals; a conflict disables both
    assign ext_req = !conflict && ((has_one && search_one_i) || (has_two && search_two_i)); // [RULE3]
    assign run_rise  = run_i && !run_q_r;
    assign ext_rise  = ext_req && !ext_q_r && run_i;
    assign loss_fall = !power_loss_i && loss_q_r;
    assign trig      = run_rise || ext_rise || (loss_fall && run_i);
    // Threshold in rated percent; 100 means rated current
    assign lvl_thr   = {8'h0, lvl_r}; // [RULE12]
    always_comb
    begin
        state_nxt     = state_r;
        freq_nxt      = freq_r;
        dir_nxt       = dir_r;
        valid_nxt     = 1'b0;
        from_loss_nxt = from_loss_r;
        use_cur_nxt   = use_cur_r;
        tim_start     = 1'b0;
        tim_ms        = wait_r;
        ev            = 3'h0;
        case (state_r)
            ST_IDLE, ST_RUN:
            begin
                if (power_loss_i)
                begin
                    state_nxt     = ST_BLOCK;
                    from_loss_nxt = 1'b1;
                    // Loss time counts from the drop, covering short losses
                    tim_start     = 1'b1; // [RULE14]
                    tim_ms        = bb_r;
                end
                else if (trig && (ext_req || sel_r[`MSS_SEL_EN_BIT] || from_loss_r)) // [RULE8] [RULE11]
                begin
                    state_nxt = ST_WAIT;
                    tim_start = 1'b1; // [RULE6]
                    tim_ms    = wait_r;
                end
                else if (run_rise)
                begin
                    // No search: start from lowest output frequency
                    freq_nxt  = 16'h0; // [RULE1]
                    dir_nxt   = 1'b0;
                    valid_nxt = 1'b1;
                    state_nxt = ST_RUN;
                end
                else if (!run_i)
                    state_nxt = ST_IDLE;
            end
            ST_BLOCK:
            begin
                // Output leaves block only if the loss has ended when the baseblock timer finishes
                if (tim_done && !power_loss_i && run_i) // [RULE14]
                begin
                    state_nxt = ST_WAIT;
                    tim_start = 1'b1; // [RULE6]
                    tim_ms    = wait_r;
                end
                else if (tim_done && !power_loss_i)
                    state_nxt = ST_IDLE;
            end
            ST_WAIT:
            begin
                if (tim_done)
                begin
                    valid_nxt = 1'b1;
                    use_cur_nxt = sel_r[`MSS_SEL_CURDET_BIT] && !encoder_mode_i;
                    if (encoder_mode_i)
                    begin
                        freq_nxt  = freq_i.enc_freq; // [RULE4]
                        dir_nxt   = 1'b0;
                        state_nxt = ST_RECOVER;
                    end
                    else if (!sel_r[`MSS_SEL_CURDET_BIT])
                    begin
                        // Both commands behave alike here
                        freq_nxt  = freq_i.est_freq; // [RULE1] [RULE2] [RULE9]
                        dir_nxt   = freq_i.est_dir; // [RULE9]
                        state_nxt = ST_RECOVER;
                    end
                    else
                    begin
                        if (from_loss_r && !ext_req)
                            freq_nxt = freq_i.loss_freq; // [RULE10]
                        else if (has_two && search_two_i)
                            freq_nxt = freq_i.ref_freq; // [RULE2]
                        else
                            freq_nxt = freq_i.max_freq; // [RULE1] [RULE10]
                        dir_nxt   = 1'b0;
                        state_nxt = ST_SEARCH;
                    end
                end
            end
            ST_SEARCH:
            begin
                if ({8'h0, current_pct_i} < lvl_thr) // [RULE7]
                begin
                    ev[`MSS_INT_SEARCH_DONE] = 1'b1;
                    state_nxt = ST_RECOVER;
                    tim_start = 1'b1; // [RULE13]
                    tim_ms    = vrec_r;
                end
            end
            ST_RECOVER:
            begin
                if (!use_cur_r && valid_r)
                    ev[`MSS_INT_SEARCH_DONE] = 1'b1;
                if (valid_r)
                begin
                    tim_start = 1'b1; // [RULE13]
                    tim_ms    = vrec_r;
                end
                else if (tim_done)
                begin
                    ev[`MSS_INT_REC_DONE] = 1'b1;
                    from_loss_nxt = 1'b0;
                    state_nxt = ST_RUN;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (conflict)
            ev[`MSS_INT_CFG_ERR] = 1'b1; // [RULE3]
    end
    always_comb
    begin
        sel_nxt   = sel_r;
        wait_nxt  = wait_r;
        bb_nxt    = bb_r;
        vrec_nxt  = vrec_r;
        lvl_nxt   = lvl_r;
        imask_nxt = imask_r;
        ist_nxt   = ist_r;
        rdata_nxt = 16'h0;
        if (bus_i.wr)
        begin
            case (bus_i.addr)
                `MSS_ADDR_CTRL:     sel_nxt   = bus_i.wdata[1:0]; // [RULE11]
                `MSS_ADDR_WAIT:     wait_nxt  = bus_i.wdata;
                `MSS_ADDR_BB:       bb_nxt    = bus_i.wdata;
                `MSS_ADDR_VREC:     vrec_nxt  = bus_i.wdata;
                `MSS_ADDR_CURLVL:   lvl_nxt   = bus_i.wdata[7:0];
                `MSS_ADDR_INT_STAT: ist_nxt   = ist_r & ~bus_i.wdata[2:0];
                `MSS_ADDR_INT_MASK: imask_nxt = bus_i.wdata[2:0];
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle
        ist_nxt = ist_nxt | ev;
        if (bus_i.rd)
        begin
            case (bus_i.addr)
                `MSS_ADDR_CTRL:       rdata_nxt = {14'h0, sel_r};
                `MSS_ADDR_WAIT:       rdata_nxt = wait_r;
                `MSS_ADDR_BB:         rdata_nxt = bb_r;
                `MSS_ADDR_VREC:       rdata_nxt = vrec_r;
                `MSS_ADDR_CURLVL:     rdata_nxt = {8'h0, lvl_r};
                `MSS_ADDR_STATUS:     rdata_nxt = {12'h0, conflict, 3'(state_r)};
                `MSS_ADDR_INT_STAT:   rdata_nxt = {13'h0, ist_r};
                `MSS_ADDR_INT_MASK:   rdata_nxt = {13'h0, imask_r};
                `MSS_ADDR_START_FREQ: rdata_nxt = freq_r;
                default:              rdata_nxt = 16'h0;
            endcase
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state_r     <= ST_IDLE;
            freq_r      <= 16'h0;
            dir_r       <= 1'b0;
            valid_r     <= 1'b0;
            from_loss_r <= 1'b0;
            use_cur_r   <= 1'b0;
            run_q_r     <= 1'b0;
            ext_q_r     <= 1'b0;
            loss_q_r    <= 1'b0;
            sel_r       <= `MSS_SEL_RESET;
            wait_r      <= 16'(`MSS_WAIT_DEFAULT_MS);
            bb_r        <= 16'(`MSS_BB_DEFAULT_MS);
            vrec_r      <= 16'(`MSS_VREC_DEFAULT_MS);
            lvl_r       <= `MSS_CURLVL_RESET;
            ist_r       <= 3'h0;
            imask_r     <= 3'h0;
            rdata_r     <= 16'h0;
        end
        else
        begin
            state_r     <= state_nxt;
            freq_r      <= freq_nxt;
            dir_r       <= dir_nxt;
            valid_r     <= valid_nxt;
            from_loss_r <= from_loss_nxt;
            use_cur_r   <= use_cur_nxt;
            run_q_r     <= run_i;
            ext_q_r     <= ext_req;
            loss_q_r    <= power_loss_i;
            sel_r       <= sel_nxt;
            wait_r      <= wait_nxt;
            bb_r        <= bb_nxt;
            vrec_r      <= vrec_nxt;
            lvl_r       <= lvl_nxt;
            ist_r       <= ist_nxt;
            imask_r     <= imask_nxt;
            rdata_r     <= rdata_nxt;
        end
    end
    assign rdata_o       = rdata_r;
    assign block_o       = (state_r == ST_BLOCK) || (state_r == ST_WAIT);
    assign searching_o   = state_r == ST_SEARCH;
    assign curdet_o      = use_cur_r;
    assign ramp_o        = state_r == ST_RUN || state_r == ST_RECOVER;
    assign vrec_o        = state_r == ST_RECOVER;
    assign start_freq_o  = freq_r;
    assign start_dir_o   = dir_r;
    assign start_valid_o = valid_r;
    assign cfg_err_o     = conflict;
    assign irq_o         = |(ist_r & imask_r);
    chk_search_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_IDLE && run_rise && !power_loss_i && !ext_req
         && !sel_r[0] && !from_loss_r) |=> state_r == ST_RUN && freq_r == 16'h0)
        else $error("run without enable did not start low"); // [RULE8]
    chk_wait_first: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r != ST_SEARCH && state_nxt == ST_SEARCH) |-> state_r == ST_WAIT)
        else $error("search entered without wait"); // [RULE6]
    chk_cur_done: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_SEARCH && current_pct_i < lvl_r) |=> state_r == ST_RECOVER)
        else $error("current search did not complete"); // [RULE7]
    chk_est_freq: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_WAIT && tim_done && !encoder_mode_i && !sel_r[1])
        |=> freq_r == $past(freq_i.est_freq) && dir_r == $past(freq_i.est_dir))
        else $error("estimate not used"); // [RULE9]
    chk_enc_freq: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_WAIT && tim_done && encoder_mode_i)
        |=> freq_r == $past(freq_i.enc_freq) && state_r == ST_RECOVER)
        else $error("encoder frequency not used"); // [RULE4]
    chk_ref_freq: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_WAIT && tim_done && !encoder_mode_i && sel_r[1] && ext_req
         && has_two && search_two_i) |=> freq_r == $past(freq_i.ref_freq))
        else $error("reference not used"); // [RULE2]
    chk_max_freq: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_WAIT && tim_done && !encoder_mode_i && sel_r[1] && ext_req
         && !(has_two && search_two_i)) |=> freq_r == $past(freq_i.max_freq))
        else $error("maximum not used"); // [RULE1] [RULE10]
    chk_cfg_err: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        conflict |=> ist_r[`MSS_INT_CFG_ERR] && cfg_err_o == conflict)
        else $error("conflict not flagged"); // [RULE3]
    chk_block_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_BLOCK && !tim_done) |=> state_r == ST_BLOCK)
        else $error("baseblock left early"); // [RULE14]
    chk_vrec_path: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_RECOVER && $past(state_r) != ST_RECOVER) |-> valid_r || $past(tim_start))
        else $error("recovery without start"); // [RULE13]
    cov_est: cover property (@(posedge clk_i) state_r == ST_RECOVER && !use_cur_r);
    cov_cur: cover property (@(posedge clk_i) state_r == ST_SEARCH ##1 state_r == ST_RECOVER);
    cov_loss: cover property (@(posedge clk_i) state_r == ST_BLOCK ##1 state_r == ST_WAIT);
    cov_irq: cover property (@(posedge clk_i) irq_o);
endmodule : mss_sequencer
`default_nettype wire

// file: pkg/mss_defs.svh
// Constants for the motor speed search sequencer
`ifndef MSS_DEFS_SVH
`define MSS_DEFS_SVH
`define MSS_FN_SEARCH_ONE     8'h61
`define MSS_FN_SEARCH_TWO     8'h62
`define MSS_SEL_EN_BIT        0
`define MSS_SEL_CURDET_BIT    1
`define MSS_SEL_RESET         2'h2
`define MSS_CLK_HZ            20000000
`define MSS_WAIT_DEFAULT_MS   200
`define MSS_VREC_DEFAULT_MS   300
`define MSS_BB_DEFAULT_MS     100
`define MSS_CYC_PER_MS        (`MSS_CLK_HZ / 1000)
`define MSS_RATED_PCT         8'h64
`define MSS_CURLVL_RESET      8'h78
`define MSS_INT_SEARCH_DONE   0
`define MSS_INT_CFG_ERR       1
`define MSS_INT_REC_DONE      2
`define MSS_ADDR_CTRL         4'h0
`define MSS_ADDR_WAIT         4'h1
`define MSS_ADDR_BB           4'h2
`define MSS_ADDR_VREC         4'h3
`define MSS_ADDR_CURLVL       4'h4
`define MSS_ADDR_STATUS       4'h5
`define MSS_ADDR_INT_STAT     4'h6
`define MSS_ADDR_INT_MASK     4'h7
`define MSS_ADDR_START_FREQ   4'h8
`endif

// file: pkg/mss_pkg.sv
// Types shared by the speed search sequencer files
`default_nettype none
package mss_pkg;
    typedef enum logic [1:0] {
        MSS_SRC_LOWEST,
        MSS_SRC_ESTIMATE,
        MSS_SRC_MAXIMUM,
        MSS_SRC_REFERENCE
    } mss_src_type;
    typedef struct packed {
        logic [15:0] est_freq;
        logic [15:0] max_freq;
        logic [15:0] ref_freq;
        logic [15:0] loss_freq;
        logic [15:0] enc_freq;
        logic        est_dir;
    } mss_freq_type;
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } mss_bus_type;
endpackage : mss_pkg
`default_nettype wire

// file: logic/mss_timer.sv
// Millisecond-based down timer
`default_nettype none
`include "mss_defs.svh"
module mss_timer #(
    parameter int CYC_PER_MS = `MSS_CYC_PER_MS
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        start_i,
    input  wire logic [15:0] ms_i,
    output logic             done_o
);
    logic [15:0] ms_r, ms_nxt;
    logic [31:0] cyc_r, cyc_nxt;
    logic        run_r, run_nxt;
    always_comb
    begin
        ms_nxt  = ms_r;
        cyc_nxt = cyc_r;
        run_nxt = run_r;
        if (start_i)
        begin
            ms_nxt  = ms_i;
            cyc_nxt = 32'h0;
            run_nxt = 1'b1;
        end
        else if (run_r)
        begin
            if (ms_r == 16'h0)
                run_nxt = 1'b0;
            else if (cyc_r == 32'(CYC_PER_MS - 1))
            begin
                cyc_nxt = 32'h0;
                ms_nxt  = ms_r - 16'h1;
            end
            else
                cyc_nxt = cyc_r + 32'h1;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            ms_r  <= 16'h0;
            cyc_r <= 32'h0;
            run_r <= 1'b0;
        end
        else
        begin
            ms_r  <= ms_nxt;
            cyc_r <= cyc_nxt;
            run_r <= run_nxt;
        end
    end
    // Zero time finishes one cycle after start
    assign done_o = run_r && (ms_r == 16'h0);
endmodule : mss_timer
`default_nettype wire

// file: logic/mss_cfg_check.sv
// Terminal function scan for conflicting search commands
`default_nettype none
`include "mss_defs.svh"
module mss_cfg_check (
    input  wire logic [39:0] term_fn_i,
    output logic             has_one_o,
    output logic             has_two_o,
    output logic             conflict_o
);
    logic [4:0] one_hit;
    logic [4:0] two_hit;
    for (genvar g = 0; g < 5; g++)
    begin : g_term
        assign one_hit[g] = term_fn_i[g*8 +: 8] == `MSS_FN_SEARCH_ONE;
        assign two_hit[g] = term_fn_i[g*8 +: 8] == `MSS_FN_SEARCH_TWO;
    end
    assign has_one_o  = |one_hit;
    assign has_two_o  = |two_hit;
    assign conflict_o = has_one_o && has_two_o;
endmodule : mss_cfg_check
`default_nettype wire

// file: test/mss_ext_seq.sv
// Outside sequence model driving the run and search command inputs
`default_nettype none
module mss_ext_seq (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        go_i,
    input  wire logic [1:0]  kind_i,
    input  wire logic [15:0] hold_i,
    input  wire logic        stop_i,
    output logic             run_o,
    output logic             one_o,
    output logic             two_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] left_r;
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            run_o  <= 1'b0;
            one_o  <= 1'b0;
            two_o  <= 1'b0;
            left_r <= 16'h0;
        end
        else if (go_i)
        begin
            run_o  <= 1'b1;
            one_o  <= kind_i == 2'h1;
            two_o  <= kind_i == 2'h2;
            left_r <= hold_i; // Run and search rise together and count down
        end
        else if (left_r != 16'h0)
            left_r <= left_r - 16'h1; // Both held for at least the baseblock time
        else
        begin
            one_o <= 1'b0;
            two_o <= 1'b0;
            if (stop_i)
                run_o <= 1'b0; // Run only drops once the hold has run out
        end
    end
endmodule : mss_ext_seq
`default_nettype wire

// file: test/test_mss_sequencer.sv
// Self-checking bench for the speed search sequencer
`default_nettype none
`include "mss_defs.svh"
module test_mss_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import mss_pkg::*;
    localparam logic [1:0]  C_SEL  [8] = '{2'h1, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0, 2'h3, 2'h1};
    localparam logic [1:0]  C_KIND [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0};
    localparam logic [15:0] C_FREQ [8] = '{16'h1234, 16'h0000, 16'h1234, 16'h3000,
                                           16'h0abc, 16'h1234, 16'h3000, 16'h0777};
    logic         clk_i = 1'b0;
    logic         sys_rst_i = 1'b1;
    mss_bus_type  bus_s = '0;
    logic [39:0]  term_fn_s = 40'h0;
    mss_freq_type freq_s = '{16'h1234, 16'h3000, 16'h0abc, 16'h2222, 16'h0777, 1'b1};
    logic [7:0]   cur_s = 8'hc8;
    logic [1:0]   kind_s = 2'h0;
    logic         loss_s = 1'b0;
    logic         enc_s = 1'b0;
    logic         go_s = 1'b0;
    logic         stop_s = 1'b0;
    logic         run_s, one_s, two_s, blk;
    logic [15:0]  rdata_o, start_freq_o, rv;
    logic         block_o, searching_o, start_dir_o, start_valid_o;
    logic         curdet_o, ramp_o, vrec_o, cfg_err_o, irq_o;
    int           fail_count = 0;
    int           n_checks = 0;
    int           nb, nv;
    always #25 clk_i = ~clk_i;
    mss_ext_seq u_mss_ext_seq (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .go_i(go_s),
        .kind_i(kind_s), .hold_i(16'h00c8), .stop_i(stop_s), .run_o(run_s),
        .one_o(one_s), .two_o(two_s));
    // Small ms scale keeps the delays short
    mss_sequencer #(.CYC_PER_MS(2)) u_mss_sequencer (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .bus_i(bus_s), .rdata_o(rdata_o), .term_fn_i(term_fn_s), .run_i(run_s),
        .search_one_i(one_s), .search_two_i(two_s), .power_loss_i(loss_s),
        .encoder_mode_i(enc_s), .freq_i(freq_s), .current_pct_i(cur_s),
        .block_o(block_o), .searching_o(searching_o), .start_freq_o(start_freq_o),
        .start_dir_o(start_dir_o), .start_valid_o(start_valid_o), .curdet_o(curdet_o),
        .ramp_o(ramp_o), .vrec_o(vrec_o), .cfg_err_o(cfg_err_o), .irq_o(irq_o));
    task automatic wrap_up();
        if (fail_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        bus_s <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_s <= '0;
    endtask : wr
    task automatic rc(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        bus_s <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_s <= '0;
        #1;
        check(rdata_o, exp);
    endtask : rc
    // Bounded wait for a start pulse or for the run state, counting blocked or recovery cycles
    task automatic wait_for(input bit to_run, output int n);
        n = 0;
        for (int i = 0; i < 1000; i++)
        begin
            @(posedge clk_i);
            #1;
            if (to_run ? (ramp_o === 1'b1 && vrec_o === 1'b0) : (start_valid_o === 1'b1))
                return;
            n += to_run ? int'(vrec_o === 1'b1) : int'(block_o === 1'b1);
        end
        fail_count++;
        wrap_up();
    endtask : wait_for
    task automatic finish_search();
        repeat (4) @(posedge clk_i);
        #1;
        check({15'h0, searching_o}, 16'h1);
        @(posedge clk_i);
        cur_s <= 8'h32;
        wait_for(1'b1, nv);
        @(posedge clk_i);
        cur_s <= 8'hc8;
    endtask : finish_search
    task automatic launch(input logic [1:0] k);
        @(posedge clk_i);
        kind_s <= k;
        go_s   <= 1'b1;
        @(posedge clk_i);
        go_s   <= 1'b0;
        wait_for(1'b0, nb);
    endtask : launch
    initial
    begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rc(`MSS_ADDR_CTRL, 16'h2);
        rc(`MSS_ADDR_WAIT, 16'h00c8);
        rc(`MSS_ADDR_BB, 16'h0064);
        rc(`MSS_ADDR_VREC, 16'h012c);
        rc(`MSS_ADDR_CURLVL, 16'h0078);
        rc(`MSS_ADDR_INT_MASK, 16'h0);
        rc(4'h9, 16'h0);
        @(posedge clk_i);
        term_fn_s <= 40'h0000006261;
        repeat (2) @(posedge clk_i);
        #1;
        check({15'h0, cfg_err_o}, 16'h1);
        check({15'h0, irq_o}, 16'h0);
        wr(`MSS_ADDR_INT_MASK, 16'h7);
        #1;
        check({15'h0, irq_o}, 16'h1);
        @(posedge clk_i);
        term_fn_s <= 40'h0;
        rc(`MSS_ADDR_INT_STAT, 16'h2);
        wr(`MSS_ADDR_INT_STAT, 16'h2);
        rc(`MSS_ADDR_INT_STAT, 16'h0);
        check({15'h0, irq_o}, 16'h0);
        wr(`MSS_ADDR_WAIT, 16'h1);
        wr(`MSS_ADDR_VREC, 16'h1);
        for (int i = 0; i < 8; i++)
        begin
            wr(`MSS_ADDR_CTRL, {14'h0, C_SEL[i]});
            term_fn_s <= (C_KIND[i] == 2'h2) ? 40'h0062000000 : 40'h61;
            enc_s <= (i == 7);
            launch(C_KIND[i]);
            check(start_freq_o, C_FREQ[i]);
            check({15'h0, curdet_o}, {15'h0, C_SEL[i][1]});
            if (C_FREQ[i] == 16'h1234)
                check({15'h0, start_dir_o}, 16'h1);
            blk = C_SEL[i][0] || C_KIND[i] != 2'h0;
            check(16'(blk ? (nb >= 2 && nb <= 8) : nb == 0), 16'h1);
            if (C_SEL[i][1])
                finish_search();
            else
                wait_for(1'b1, nv);
            check(16'(blk ? nv >= 2 : nv == 0), 16'h1);
            repeat (200) @(posedge clk_i);
            stop_s <= 1'b1;
            repeat (3) @(posedge clk_i);
            stop_s <= 1'b0;
        end
        enc_s <= 1'b0;
        rc(`MSS_ADDR_INT_STAT, 16'h5);
        wr(`MSS_ADDR_INT_STAT, 16'h5);
        rc(`MSS_ADDR_INT_STAT, 16'h0);
        // Short loss while running: block outlasts the loss
        wr(`MSS_ADDR_CTRL, 16'h2);
        wr(`MSS_ADDR_WAIT, 16'h0);
        launch(2'h0);
        check(start_freq_o, 16'h0);
        @(posedge clk_i);
        loss_s <= 1'b1;
        repeat (3) @(posedge clk_i);
        loss_s <= 1'b0;
        wait_for(1'b0, nb);
        check(start_freq_o, 16'h2222);
        check(16'(nb >= 190 && nb <= 206), 16'h1);
        finish_search();
        rc(`MSS_ADDR_START_FREQ, 16'h2222);
        wrap_up();
    end
endmodule : test_mss_sequencer
`default_nettype wire
